// *** dv/bc_model.sv ***
// bus controller model feeding sliced words into the engine
`timescale 1ns/1ps
module bc_model (
	input wire logic sysClk,
	input wire logic [4:0] txIdx,
	output logic rxStb,
	output logic [39:0] rxHalves,
	output logic [15:0] txWordIn
);
	// transmit data follows the index at once, as the engine expects
	assign txWordIn = {11'h5A0, txIdx};
	initial begin
		rxStb = 1'b0;
		rxHalves = 40'h0;
	end
	// one word, taken waitCyc edges after the call; the only bus driver
	// the caller spaces words of a message by one word time
	// commands come at least 3000 cycles apart, well past the gap
	task sendWord(input logic isCmd, input logic [15:0] d, input logic badPar, input int waitCyc);
		logic [39:0] h;
		h[39:34] = isCmd ? 6'h38 : 6'h07;
		for (int i = 0; i < 16; i++) begin
			h[33-2*i -: 2] = {d[15-i], ~d[15-i]};
		end
		h[1] = ~^d ^ badPar; // badPar flips the odd parity on purpose
		h[0] = ~h[1];
		repeat (waitCyc - 1) @(posedge sysClk);
		rxHalves <= h;
		rxStb <= 1'b1;
		@(posedge sysClk);
		rxStb <= 1'b0;
		rxHalves <= ~h; // a released line shows no stale copy
	endtask : sendWord
endmodule : bc_model

// *** dv/rt_msg_engine_monitor.sv ***
// port checker for the remote terminal message engine
`timescale 1ns/1ps
module rt_msg_engine_monitor #(
	parameter int FAILSAFE_CYC = rt_pkg::FAILSAFE_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rxStb,
	input wire logic txOut,
	input wire logic txEn,
	input wire logic dataStb,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	// --------------------------------
	// helper counters
	// --------------------------------
	logic [12:0] sinceRx_ff; // cycles since the last word arrived, saturates
	logic [16:0] txRun_ff; // length of the current burst on the line
	// saturation keeps a long idle spell from wrapping into the window
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sinceRx_ff <= '1;
			txRun_ff <= '0;
		end else begin
			sinceRx_ff <= rxStb ? 13'h0 : (&sinceRx_ff ? sinceRx_ff : sinceRx_ff + 13'h1);
			txRun_ff <= txEn ? txRun_ff + 17'h1 : 17'h0;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// --------------------------------
	// assertions
	// --------------------------------
	sequence wbReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ackPulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_wb_answer: assert property (wbReq |=> ackPulse)
		else $error("bus answer not one cycle after request");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	chk_idle_low: assert property (!txEn |-> !txOut)
		else $error("line driven while idle");
	chk_fail_safe: assert property (txRun_ff <= FAILSAFE_CYC)
		else $error("transmission longer than the fail-safe limit");
	chk_resp_window: assert property ($rose(txEn) |->
		sinceRx_ff >= rt_pkg::RESP_MIN_CYC && sinceRx_ff <= rt_pkg::RESP_MAX_CYC)
		else $error("reply outside response window");
	chk_word_whole: assert property ($fell(txEn) |-> txRun_ff % rt_pkg::WORD_CYC == 0)
		else $error("burst not whole words");
	chk_data_cause: assert property (dataStb |-> $past(rxStb, 2))
		else $error("data strobe without a received word");
	chk_sync_lead: assert property ($rose(txEn) |-> txOut [*8])
		else $error("status sync does not start high");
endmodule : rt_msg_engine_monitor

bind rt_msg_engine rt_msg_engine_monitor #(.FAILSAFE_CYC(FAILSAFE_CYC)) rt_msg_engine_monitor_i (
	.sys_clk(sys_clk), .nrst(nrst), .rxStb(rxStb), .txOut(txOut), .txEn(txEn),
	.dataStb(dataStb), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// *** dv/tb_top.sv ***
// self-checking bench for the remote terminal message engine
`timescale 1ns/1ps
module tb_top;
	logic sysClk = 1'b0;
	logic nrst = 1'b0;
	logic rxStb, txOut, txEn, dataStb, msgDone, msgOk, wbAck;
	logic [39:0] rxHalves;
	logic [4:0] txIdx;
	logic [15:0] txWordIn, dataOut;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [3:0] wbAdr = 4'h0;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDatO, q, w;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	always #4 sysClk = ~sysClk;
	// fail-safe shortened, still above a two-word reply
	rt_msg_engine #(.FAILSAFE_CYC(6000)) rt_msg_engine_i (.sys_clk(sysClk), .nrst(nrst),
		.rxStb(rxStb), .rxHalves(rxHalves), .txOut(txOut), .txEn(txEn), .txIdx(txIdx),
		.txWordIn(txWordIn), .dataOut(dataOut), .dataStb(dataStb), .dataIdx(), .dataIsCmd(),
		.msgDone(msgDone), .msgOk(msgOk), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
	bc_model bc_model_i (.sysClk(sysClk), .txIdx(txIdx), .rxStb(rxStb), .rxHalves(rxHalves),
		.txWordIn(txWordIn));
	// --------------------------------
	// shared tasks
	// --------------------------------
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	// a hang counts as a mismatch
	always @(posedge sysClk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one classic cycle; read data lands in q at the ack edge
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge sysClk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= d;
		@(posedge sysClk);
		while (wbAck !== 1'b1) @(posedge sysClk);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wb
	// waits for data strobe (0), message done (1) or line enable (2)
	task waitEv(input int which, input int lim, output int k);
		k = 0;
		while (k < lim && !((which == 0 && dataStb === 1'b1) ||
			(which == 1 && msgDone === 1'b1) || (which == 2 && txEn === 1'b1))) begin
			@(posedge sysClk);
			#1;
			k++;
		end
	endtask : waitEv
	// samples the first half of each information bit, word after word
	task expectReply(input int nw, input logic [31:0] exp);
		int c;
		waitEv(2, 2000, c);
		chk("reply delay", 32'(c >= rt_pkg::RESP_MIN_CYC - 4 && c <= rt_pkg::RESP_MAX_CYC), 32'h1);
		c = 0;
		w = 32'h0;
		for (int k = 0; k < nw; k++) begin
			for (int i = 0; i < 16; i++) begin
				while (c < k * rt_pkg::WORD_CYC + 406 + 125 * i) begin
					@(posedge sysClk);
					c++;
				end
				#1 w = {w[30:0], txOut};
			end
		end
		chk("reply words", w, exp);
	endtask : expectReply
	// a controller waits past the no-response time before giving up
	task expectSilent();
		waitEv(2, 2000, n);
		chk("no reply", n, 2000);
	endtask : expectSilent
	// --------------------------------
	// scenarios
	// --------------------------------
	task t_regs();
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", q, 32'h20);
		wb(1'b1, 4'h0, 32'h25);
		wb(1'b1, 4'h4, 32'hC3A5);
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl", q, 32'h25);
		wb(1'b0, 4'h4, 32'h0);
		chk("mode data", q, 32'hC3A5);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", q, 32'h0);
	endtask : t_regs
	task t_good();
		bc_model_i.sendWord(1'b1, 16'h2822, 1'b0, 3000);
		for (int i = 0; i < 2; i++) begin
			bc_model_i.sendWord(1'b0, 16'h1234 ^ 16'(i), 1'b0, 2500);
			waitEv(0, 4, n);
			chk("rx data", dataOut, 16'h1234 ^ 16'(i));
		end
		waitEv(1, 4, n);
		chk("msg ok", msgOk, 1'b1);
		expectReply(1, 32'h2800);
	endtask : t_good
	// bad parity, then a late data word
	task t_bad();
		for (int k = 0; k < 2; k++) begin
			bc_model_i.sendWord(1'b1, 16'h2821, 1'b0, 3000);
			bc_model_i.sendWord(1'b0, 16'hBEEF, k == 0, k ? 2800 : 2500);
			expectSilent();
			wb(1'b0, 4'h8, 32'h0);
			chk("error bit", q[rt_pkg::ST_ME], 1'b1);
		end
	endtask : t_bad
	task t_bcast();
		logic [15:0] cmds [3];
		cmds = '{16'hF821, 16'hF810, 16'hFC01};
		for (int k = 0; k < 3; k++) begin
			bc_model_i.sendWord(1'b1, cmds[k], 1'b0, 3000);
			if (k < 2) begin
				bc_model_i.sendWord(1'b0, 16'h0F0F, 1'b0, 2500);
			end
			expectSilent();
			wb(1'b0, 4'h8, 32'h0);
			chk("bcast bit", q[rt_pkg::ST_BCR], 1'b1);
		end
	endtask : t_bcast
	// foreign address, then own address with broken parity
	task t_foreign();
		for (int k = 0; k < 2; k++) begin
			bc_model_i.sendWord(1'b1, k ? 16'h2C10 : 16'h3421, k == 1, 3000);
			expectSilent();
		end
	endtask : t_foreign
	// status and mode data back to back; earlier flags now cleared
	task t_mode_tx();
		bc_model_i.sendWord(1'b1, 16'h2C10, 1'b0, 3000);
		expectReply(2, 32'h2800_C3A5);
	endtask : t_mode_tx
	initial begin
		repeat (20) @(posedge sysClk);
		nrst <= 1'b1;
		t_regs();
		t_good();
		t_bad();
		t_bcast();
		t_foreign();
		t_mode_tx();
		report_and_stop();
	end
endmodule : tb_top

// *** hdl/rt_msg_engine.sv ***
// remote terminal message engine: command handling, replies, wishbone regs
`timescale 1ns/1ps
module rt_msg_engine #(
	parameter int FAILSAFE_CYC = rt_pkg::FAILSAFE_CYC,
	parameter logic ILLEGAL_MON = 1'b1,
	parameter logic [31:0] RX_SA_MASK = 32'hFFFF_FFFF,
	parameter logic [31:0] TX_SA_MASK = 32'hFFFF_FFFF,
	parameter logic [31:0] MODE_MASK = 32'hFFFF_FFFF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rxStb,
	input wire logic [39:0] rxHalves,
	output logic txOut,
	output logic txEn,
	output logic [4:0] txIdx,
	input wire logic [15:0] txWordIn,
	output logic [15:0] dataOut,
	output logic dataStb,
	output logic [4:0] dataIdx,
	output logic dataIsCmd,
	output logic msgDone,
	output logic msgOk,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	localparam logic [rt_pkg::FS_W-1:0] FS_LIM = rt_pkg::FS_W'(FAILSAFE_CYC);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		rt_pkg::state_e st;
		logic [rt_pkg::TMR_W-1:0] tmr; // phase timer
		logic [rt_pkg::TMR_W-1:0] gapTmr; // since last word on bus
		logic [5:0] want; // data words expected
		logic [5:0] got;
		logic [5:0] txLeft;
		logic [4:0] txIdx;
		logic bcast;
		logic tr;
		logic mode;
		logic illegal;
		logic me; // message error flag
		logic bcr; // broadcast received flag
		logic failTrip;
		logic gapShort;
		logic [rt_pkg::FS_W-1:0] failCnt;
		logic ldStb;
		logic kill;
		logic [39:0] ldHalves;
		logic [15:0] lastCmd;
		logic [15:0] sts; // last status word built
		logic [15:0] dOut;
		logic dStb;
		logic dIsCmd;
		logic [4:0] dIdx;
		logic done;
		logic ok;
		logic [11:0] ctrl;
		logic [15:0] modeData;
		logic ack;
		logic [31:0] rdat;
	} eng_s;
	localparam eng_s RST = '{st: rt_pkg::ST_IDLE, ctrl: rt_pkg::CTRL_RST,
		modeData: rt_pkg::MODEDATA_RST, default: '0};
	eng_s eng_ff, nxt_eng;
	logic encFree; // encoder holding slot empty
	logic encBusy;
	// decode of the word just validated
	logic [4:0] wAddr;
	logic wTr;
	logic [4:0] wSa;
	logic [4:0] wWc;
	logic wMode;
	logic wBc;
	logic wHit;
	logic [5:0] wCnt;
	logic vStb;
	logic vOk;
	logic vCmd;
	logic [15:0] vData;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte-lane merge for wishbone writes
	function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : wrMerge
	// unimplemented subaddress or mode code for this terminal
	function automatic logic isIllegal(input logic [15:0] c);
		logic m;
		m = (c[9:5] == rt_pkg::MODE_SA_LO) || (c[9:5] == rt_pkg::MODE_SA_HI);
		if (m) begin
			return !MODE_MASK[c[4:0]];
		end
		return c[10] ? !TX_SA_MASK[c[9:5]] : !RX_SA_MASK[c[9:5]];
	endfunction : isIllegal
	// ----------------------------------------
	// submodules
	// ----------------------------------------
	rx_word_check u_chk (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.rxStb(rxStb),
		.rxHalves(rxHalves),
		.vStb(vStb),
		.vOk(vOk),
		.vCmd(vCmd),
		.vData(vData)
	);
	tx_word_enc u_enc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ldStb(eng_ff.ldStb),
		.ldHalves(eng_ff.ldHalves),
		.kill(eng_ff.kill),
		.txOut(txOut),
		.txEn(encBusy),
		.holdFree(encFree)
	);
	assign txEn = encBusy;
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign wAddr = vData[15:11];
	assign wTr = vData[10];
	assign wSa = vData[9:5];
	assign wWc = vData[4:0];
	assign wMode = (wSa == rt_pkg::MODE_SA_LO) || (wSa == rt_pkg::MODE_SA_HI);
	// monitor mode never takes broadcast, only the own address
	assign wBc = (wAddr == rt_pkg::BCAST_ADDR) && eng_ff.ctrl[rt_pkg::C_BCEN]
		&& !eng_ff.ctrl[rt_pkg::C_MON];
	assign wHit = wBc || (wAddr == eng_ff.ctrl[4:0]);
	assign wCnt = wMode ? {5'h00, wWc[4]} : ((wWc == 5'h00) ? rt_pkg::WC_MAX : {1'b0, wWc});
	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic [15:0] stsW;
		logic [31:0] mrgCtrl; // merged control write, cut to register width below
		logic [31:0] mrgMode; // merged mode data write
		stsW = '0;
		mrgCtrl = '0;
		mrgMode = '0;
		nxt_eng = eng_ff;
		nxt_eng.ldStb = 1'b0;
		nxt_eng.kill = 1'b0;
		nxt_eng.dStb = 1'b0;
		nxt_eng.done = 1'b0;
		if (eng_ff.tmr != '1) begin
			nxt_eng.tmr = eng_ff.tmr + 1'b1;
		end
		if (eng_ff.gapTmr != '1) begin
			nxt_eng.gapTmr = eng_ff.gapTmr + 1'b1;
		end
		// status word: flags plus the live subsystem levels
		stsW[15:11] = eng_ff.ctrl[4:0];
		stsW[rt_pkg::ST_ME] = eng_ff.me;
		stsW[rt_pkg::ST_SR] = eng_ff.ctrl[rt_pkg::C_SR];
		stsW[rt_pkg::ST_BCR] = eng_ff.bcr;
		stsW[rt_pkg::ST_BUSY] = eng_ff.ctrl[rt_pkg::C_BUSY];
		stsW[rt_pkg::ST_SSF] = eng_ff.ctrl[rt_pkg::C_SSF];
		stsW[rt_pkg::ST_DBCA] = eng_ff.ctrl[rt_pkg::C_DBCA];
		stsW[rt_pkg::ST_TF] = eng_ff.ctrl[rt_pkg::C_TF];
		// kept live so software sees flags even when the reply was withheld
		nxt_eng.sts = stsW;
		// timeouts per phase
		case (eng_ff.st)
			rt_pkg::ST_RX: begin
				if (eng_ff.tmr > rt_pkg::T_WORD_HI) begin
					nxt_eng.me = 1'b1;
					nxt_eng.st = rt_pkg::ST_IDLE;
					nxt_eng.done = 1'b1;
					nxt_eng.ok = 1'b0;
				end
			end
			rt_pkg::ST_PEER: begin
				// peer silent past the no-response wait: drop message
				if (eng_ff.tmr > rt_pkg::T_PEER) begin
					nxt_eng.me = 1'b1;
					nxt_eng.st = rt_pkg::ST_IDLE;
					nxt_eng.done = 1'b1;
					nxt_eng.ok = 1'b0;
				end
			end
			rt_pkg::ST_RESP: begin
				if (eng_ff.tmr == rt_pkg::T_RESP) begin
					nxt_eng.failCnt = '0;
					nxt_eng.sts = stsW;
					if (eng_ff.failTrip) begin
						nxt_eng.st = rt_pkg::ST_IDLE; // tripped: stay off the bus
					end else begin
						nxt_eng.ldStb = 1'b1;
						nxt_eng.ldHalves = rt_pkg::encWord(1'b1, stsW);
						nxt_eng.txLeft = eng_ff.tr ? eng_ff.want : 6'h00;
						nxt_eng.txIdx = '0;
						nxt_eng.st = rt_pkg::ST_TX;
					end
				end
			end
			rt_pkg::ST_TX: begin
				if (encBusy) begin
					nxt_eng.failCnt = eng_ff.failCnt + 1'b1;
				end
				if (eng_ff.failCnt >= FS_LIM) begin
					nxt_eng.kill = 1'b1;
					nxt_eng.failTrip = 1'b1;
					nxt_eng.st = rt_pkg::ST_IDLE;
				end else if (encFree && !eng_ff.ldStb && eng_ff.txLeft != 6'h00) begin
					// queued while the previous word shifts, so no gap
					nxt_eng.ldStb = 1'b1;
					nxt_eng.ldHalves = rt_pkg::encWord(1'b0,
						eng_ff.mode ? eng_ff.modeData : txWordIn);
					nxt_eng.txLeft = eng_ff.txLeft - 6'h01;
					nxt_eng.txIdx = eng_ff.txIdx + 5'h01;
				end else if (encFree && !eng_ff.ldStb && !encBusy) begin
					nxt_eng.st = rt_pkg::ST_IDLE;
				end
			end
			default: begin
			end
		endcase
		// received words; own transmission is half duplex and ignored
		if (vStb && eng_ff.st != rt_pkg::ST_TX) begin
			nxt_eng.gapTmr = '0;
			if (eng_ff.ctrl[rt_pkg::C_MON]) begin
				nxt_eng.dOut = vData; // monitor capture of all good words
				nxt_eng.dStb = vOk;
				nxt_eng.dIsCmd = vCmd;
				nxt_eng.dIdx = '0;
			end
			if (vOk && vCmd && wHit) begin
				// a fresh command overrides whatever was under way
				nxt_eng.lastCmd = vData;
				nxt_eng.me = 1'b0;
				nxt_eng.bcr = 1'b0;
				nxt_eng.failTrip = 1'b0;
				nxt_eng.gapShort = (eng_ff.st == rt_pkg::ST_IDLE)
					&& (eng_ff.gapTmr < rt_pkg::T_GAP);
				nxt_eng.tmr = '0;
				nxt_eng.got = '0;
				nxt_eng.want = wCnt;
				nxt_eng.bcast = wBc;
				nxt_eng.tr = wTr;
				nxt_eng.mode = wMode;
				nxt_eng.illegal = ILLEGAL_MON && isIllegal(vData);
				if (wTr && wBc) begin
					// broadcast transmit: only the no-data mode form is meaningful
					nxt_eng.st = rt_pkg::ST_IDLE;
					if (wMode && !wWc[4]) begin
						nxt_eng.bcr = 1'b1;
						nxt_eng.done = 1'b1;
						nxt_eng.ok = 1'b1;
					end
				end else if (wTr) begin
					nxt_eng.me = nxt_eng.illegal;
					if (nxt_eng.illegal || eng_ff.ctrl[rt_pkg::C_BUSY]) begin
						nxt_eng.want = 6'h00; // status only
					end
					nxt_eng.st = rt_pkg::ST_RESP;
					nxt_eng.done = 1'b1;
					nxt_eng.ok = !nxt_eng.illegal;
				end else if (wCnt == 6'h00) begin
					nxt_eng.done = 1'b1;
					nxt_eng.ok = !nxt_eng.illegal;
					nxt_eng.bcr = wBc;
					nxt_eng.me = nxt_eng.illegal;
					nxt_eng.st = wBc ? rt_pkg::ST_IDLE : rt_pkg::ST_RESP;
				end else begin
					nxt_eng.st = rt_pkg::ST_RX;
				end
			end else if (eng_ff.st == rt_pkg::ST_RX) begin
				if (vOk && vCmd && eng_ff.got == 6'h00 && wTr) begin
					nxt_eng.st = rt_pkg::ST_PEER;
					nxt_eng.tmr = '0;
				end else if (!vOk || vCmd || eng_ff.tmr < rt_pkg::T_WORD_LO) begin
					// bad word or early sync spoils the whole message
					nxt_eng.me = 1'b1;
					nxt_eng.st = rt_pkg::ST_IDLE;
					nxt_eng.done = 1'b1;
					nxt_eng.ok = 1'b0;
				end else begin
					nxt_eng.got = eng_ff.got + 6'h01;
					nxt_eng.tmr = '0;
					nxt_eng.dOut = vData;
					nxt_eng.dStb = 1'b1;
					nxt_eng.dIsCmd = 1'b0;
					nxt_eng.dIdx = eng_ff.got[4:0];
					if (eng_ff.got + 6'h01 == eng_ff.want) begin
						nxt_eng.done = 1'b1;
						nxt_eng.ok = !eng_ff.illegal;
						nxt_eng.me = eng_ff.illegal;
						if (eng_ff.bcast) begin
							nxt_eng.bcr = 1'b1;
							nxt_eng.st = rt_pkg::ST_IDLE;
						end else begin
							nxt_eng.st = rt_pkg::ST_RESP;
						end
					end
				end
			end else if (eng_ff.st == rt_pkg::ST_PEER && vOk && vCmd) begin
				nxt_eng.st = rt_pkg::ST_RX; // peer status seen, data follows
				nxt_eng.tmr = '0;
			end
			// other words fall through silently
		end
		// wishbone slave, answers one cycle after the strobe
		nxt_eng.ack = wb_cyc_i && wb_stb_i && !eng_ff.ack;
		if (wb_cyc_i && wb_stb_i && !eng_ff.ack) begin
			if (wb_we_i && wb_adr_i == rt_pkg::REG_CTRL) begin
				mrgCtrl = wrMerge({20'h00000, eng_ff.ctrl}, wb_dat_i, wb_sel_i);
				nxt_eng.ctrl = mrgCtrl[11:0];
			end
			if (wb_we_i && wb_adr_i == rt_pkg::REG_MODEDATA) begin
				mrgMode = wrMerge({16'h0000, eng_ff.modeData}, wb_dat_i, wb_sel_i);
				nxt_eng.modeData = mrgMode[15:0];
			end
			case (wb_adr_i)
				rt_pkg::REG_CTRL: nxt_eng.rdat = {20'h00000, eng_ff.ctrl};
				rt_pkg::REG_MODEDATA: nxt_eng.rdat = {16'h0000, eng_ff.modeData};
				rt_pkg::REG_STATUS: nxt_eng.rdat = {13'h0000, eng_ff.gapShort, encBusy,
					eng_ff.failTrip, eng_ff.sts};
				rt_pkg::REG_LASTCMD: nxt_eng.rdat = {16'h0000, eng_ff.lastCmd};
				default: nxt_eng.rdat = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			eng_ff <= RST;
		end else begin
			eng_ff <= nxt_eng;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign txIdx = eng_ff.txIdx;
	assign dataOut = eng_ff.dOut;
	assign dataStb = eng_ff.dStb;
	assign dataIdx = eng_ff.dIdx;
	assign dataIsCmd = eng_ff.dIsCmd;
	assign msgDone = eng_ff.done;
	assign msgOk = eng_ff.ok;
	assign wb_dat_o = eng_ff.rdat;
	assign wb_ack_o = eng_ff.ack;
endmodule : rt_msg_engine

// *** hdl/rt_pkg.sv ***
// shared constants, types and word helpers for the remote terminal engine
package rt_pkg;
	// ----------------------------------------
	// timing, in printed units, then cycles
	// ----------------------------------------
	localparam real CLK_MHZ = 125.0; // sys_clk rate
	localparam real RESP_MIN_US = 4.0;
	localparam real RESP_MAX_US = 12.0;
	localparam real NORESP_US = 14.0;
	localparam real GAP_US = 4.0;
	localparam real FAILSAFE_US = 800.0;
	localparam real WORD_US = 20.0; // one 20-bit word
	localparam real CONT_TOL_US = 1.0; // slack on word-to-word spacing
	localparam int RESP_MIN_CYC = int'($ceil(RESP_MIN_US * CLK_MHZ));
	localparam int RESP_MAX_CYC = int'($floor(RESP_MAX_US * CLK_MHZ));
	localparam int RESP_DLY_CYC = (RESP_MIN_CYC + RESP_MAX_CYC) / 2;
	localparam int NORESP_CYC = int'($ceil(NORESP_US * CLK_MHZ));
	localparam int GAP_CYC = int'($ceil(GAP_US * CLK_MHZ));
	localparam int FAILSAFE_CYC = int'($floor(FAILSAFE_US * CLK_MHZ));
	localparam int WORD_CYC = int'($floor(WORD_US * CLK_MHZ));
	localparam int TOL_CYC = int'($floor(CONT_TOL_US * CLK_MHZ));
	localparam int BIT_CYC = int'(CLK_MHZ); // one bit is 1 us
	localparam int HALF_A_CYC = BIT_CYC / 2;
	localparam int HALF_B_CYC = BIT_CYC - HALF_A_CYC;
	localparam int TMR_W = 13;
	localparam int FS_W = 17;
	localparam logic [TMR_W-1:0] T_RESP = TMR_W'(RESP_DLY_CYC);
	localparam logic [TMR_W-1:0] T_WORD_LO = TMR_W'(WORD_CYC - TOL_CYC);
	localparam logic [TMR_W-1:0] T_WORD_HI = TMR_W'(WORD_CYC + TOL_CYC);
	localparam logic [TMR_W-1:0] T_PEER = TMR_W'(NORESP_CYC + WORD_CYC);
	localparam logic [TMR_W-1:0] T_GAP = TMR_W'(GAP_CYC + WORD_CYC);
	localparam logic [6:0] HA_LAST = 7'(HALF_A_CYC - 1);
	localparam logic [6:0] HB_LAST = 7'(HALF_B_CYC - 1);
	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam logic [5:0] HALVES = 6'h28; // half-bits in a word
	localparam logic [5:0] SYNC_CMD = 6'h38; // command/status sync
	localparam logic [5:0] SYNC_DAT = 6'h07; // data sync
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	localparam logic [4:0] MODE_SA_LO = 5'h00;
	localparam logic [4:0] MODE_SA_HI = 5'h1F;
	localparam logic [5:0] WC_MAX = 6'h20; // count field zero means 32
	localparam int ST_ME = 10;
	localparam int ST_SR = 8;
	localparam int ST_BCR = 4;
	localparam int ST_BUSY = 3;
	localparam int ST_SSF = 2;
	localparam int ST_DBCA = 1;
	localparam int ST_TF = 0;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_MODEDATA = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_LASTCMD = 4'hC;
	localparam logic [11:0] CTRL_RST = 12'h020;
	localparam logic [15:0] MODEDATA_RST = 16'h0000;
	localparam int C_BCEN = 5;
	localparam int C_MON = 6;
	localparam int C_SR = 7;
	localparam int C_BUSY = 8;
	localparam int C_SSF = 9;
	localparam int C_DBCA = 10;
	localparam int C_TF = 11;
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_PEER, ST_RESP, ST_TX} state_e;
	// builds the 40 half-bit pattern of one word, sent msb first
	function automatic logic [39:0] encWord(input logic isCmd, input logic [15:0] d);
		logic [39:0] h;
		h = '0;
		h[39:34] = isCmd ? SYNC_CMD : SYNC_DAT;
		for (int i = 0; i < 16; i++) begin
			h[33-2*i -: 2] = {d[15-i], ~d[15-i]};
		end
		h[1:0] = {~^d, ^d}; // odd parity over data plus parity
		return h;
	endfunction : encWord
endpackage : rt_pkg

// *** hdl/rx_word_check.sv ***
// checks one sliced word: sync, manchester pairs, parity
`timescale 1ns/1ps
module rx_word_check (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rxStb,
	input wire logic [39:0] rxHalves,
	output logic vStb,
	output logic vOk,
	output logic vCmd,
	output logic [15:0] vData
);
	typedef struct packed {logic stb; logic ok; logic cmd; logic [15:0] data;} chk_s;
	chk_s chk_ff, nxt_chk;
	// ----------------------------------------
	// validation
	// ----------------------------------------
	always_comb begin
		logic pairOk;
		pairOk = 1'b1;
		nxt_chk = chk_ff;
		nxt_chk.stb = rxStb;
		for (int i = 0; i < 17; i++) begin
			pairOk = pairOk & (rxHalves[33-2*i] ^ rxHalves[32-2*i]); // no mid-bit edge fails
		end
		if (rxStb) begin
			for (int i = 0; i < 16; i++) begin
				nxt_chk.data[15-i] = rxHalves[33-2*i];
			end
			nxt_chk.cmd = rxHalves[39:34] == rt_pkg::SYNC_CMD;
			nxt_chk.ok = pairOk && (nxt_chk.cmd || rxHalves[39:34] == rt_pkg::SYNC_DAT)
				&& ((^nxt_chk.data) ^ rxHalves[1]);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			chk_ff <= '0;
		end else begin
			chk_ff <= nxt_chk;
		end
	end
	assign vStb = chk_ff.stb;
	assign vOk = chk_ff.ok;
	assign vCmd = chk_ff.cmd;
	assign vData = chk_ff.data;
endmodule : rx_word_check

// *** hdl/tx_word_enc.sv ***
// serialises words as half-bits, with one holding slot for gapless runs
`timescale 1ns/1ps
module tx_word_enc (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ldStb,
	input wire logic [39:0] ldHalves,
	input wire logic kill,
	output logic txOut,
	output logic txEn,
	output logic holdFree
);
	typedef struct packed {
		logic [39:0] sh;
		logic [5:0] left;
		logic [6:0] cnt;
		logic ph;
		logic [39:0] hold;
		logic holdV;
		logic out;
		logic en;
	} enc_s;
	enc_s enc_ff, nxt_enc;
	// ----------------------------------------
	// shifter
	// ----------------------------------------
	// half-bits alternate 62/63 cycles so each bit is exactly 1 us
	always_comb begin
		nxt_enc = enc_ff;
		if (enc_ff.en) begin
			if (enc_ff.cnt == (enc_ff.ph ? rt_pkg::HB_LAST : rt_pkg::HA_LAST)) begin
				nxt_enc.cnt = '0;
				nxt_enc.ph = ~enc_ff.ph;
				nxt_enc.sh = {enc_ff.sh[38:0], 1'b0};
				nxt_enc.left = enc_ff.left - 6'h01;
				nxt_enc.out = enc_ff.sh[38];
				if (enc_ff.left == 6'h01) begin
					nxt_enc.en = 1'b0;
					nxt_enc.out = 1'b0;
				end
			end else begin
				nxt_enc.cnt = enc_ff.cnt + 7'h01;
			end
		end
		// next word starts on the very edge the last one ends
		if (!nxt_enc.en && enc_ff.holdV) begin
			nxt_enc.sh = enc_ff.hold;
			nxt_enc.left = rt_pkg::HALVES;
			nxt_enc.cnt = '0;
			nxt_enc.ph = 1'b0;
			nxt_enc.out = enc_ff.hold[39];
			nxt_enc.en = 1'b1;
			nxt_enc.holdV = 1'b0;
		end
		if (ldStb) begin
			nxt_enc.hold = ldHalves;
			nxt_enc.holdV = 1'b1;
		end
		if (kill) begin
			nxt_enc = '0; // fail-safe cut, drop everything
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			enc_ff <= '0;
		end else begin
			enc_ff <= nxt_enc;
		end
	end
	assign txOut = enc_ff.out;
	assign txEn = enc_ff.en;
	assign holdFree = ~enc_ff.holdV;
endmodule : tx_word_enc
